// ---- logic/chaa_pkg.sv ----
package chaa_pkg;
  // Register indices
  localparam logic [7:0] CHAA_REG_THROTTLE  = 8'h08;
  localparam logic [7:0] CHAA_REG_LOCK      = 8'h0B;
  localparam logic [7:0] CHAA_REG_RESETMODE = 8'h0C;
  localparam logic [7:0] CHAA_REG_STATUS    = 8'h10;
  // Field positions and control register index
  localparam int CHAA_LOCK_BIT      = 0;
  localparam int CHAA_SLMODE_BIT    = 3;
  localparam int CHAA_DUR_MSB       = 6;
  localparam int CHAA_THR_HOLD_BIT  = 7;
  localparam int CHAA_CTL_SLOW_BIT  = 0;
  localparam int CHAA_CTL_FLUSH_BIT = 1;
  localparam int CHAA_CTL_WBMODE_BIT = 2;
  localparam logic [7:0] CHAA_REG_CONTROL = 8'h11;
  // Reset values
  localparam logic [7:0] CHAA_RST_BYTE = 8'h00;
  // Timing
  localparam int CHAA_CLK_MHZ       = 100;
  localparam int CHAA_MASTER_SET_NS = 90;
  localparam int CHAA_MASTER_SET_CYC = (CHAA_MASTER_SET_NS * CHAA_CLK_MHZ + 999) / 1000;
  localparam int CHAA_WB_HOLD_CYC   = 4;
  localparam int CHAA_DMACLK_KHZ    = 8000;
  localparam int CHAA_DMACLK_DIV    = (CHAA_CLK_MHZ * 1000) / CHAA_DMACLK_KHZ;
endpackage

// ---- logic/chaa_arbiter.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// (R1) Hidden refresh and DMA grant are never active together.
// (R2) Hidden refresh runs under CPU or local master without raising hold.
// (R3) Partner chip arbitrates granted refresh against ISA cycles.
// (R4) Original mode: CPU reset waits until CPU leaves hold.
// (R5) SL mode: reset raises hold, applied when hold and acknowledge both active.
// (R6) Other arbitration keeps running while SL reset is pending.
// (R7) Reset mode register bit selects original or SL mode.
// (R8) Power-good reset goes straight to the CPU.
// (R9) DMA hold during VL ownership drops local grant until request released.
// (R10) Throttle hold is ORed into CPU hold, outside arbitration; code ORs it into arb_hold_want, gated by lock and write-back.
// (R11) Write-back request drops hold while the current grant stays.
// (R12) Owner at write-back keeps the bus until write-back ends.
// (R13) Two write-back modes: follow request, or fixed four cycles.
// (R14) DMA owner with write-back floats upper address lines.
// (R15) Arbitration lock stops hold rising, leaves active hold alone.
// (R16) Lock plus SL mode leaves reset pending until lock is cleared.
// (R17) Bus withheld from CPU and VL 90 ns after ISA master ends.
// (R18) Throttle: each refresh request holds CPU for programmed time, optional flush.
// (R19) Throttle hold and flush have separate enables.
// (R20) Throttling active when register enable or slow input asserted.
// (R21) Throttle duration counted in 8 MHz cycles, up to 127.
// (R22) Slow and write-back inputs are synchronised first.
module chaa_arbiter
  import chaa_pkg::*;
(
  input  wire logic       sys_clk_i,           // System clock
  input  wire logic       srst_i,              // Sync reset, active high
  input  wire logic [7:0] reg_addr_i,          // Register index
  input  wire logic [7:0] reg_wdata_i,         // Write data
  input  wire logic       reg_wr_i,            // Write strobe
  input  wire logic       reg_rd_i,            // Read strobe
  output logic      [7:0] reg_rdata_o,         // Read data
  input  wire logic       power_good_reset_i,  // Power-good system reset
  input  wire logic       cpu_reset_req_i,     // CPU reset request pulse
  input  wire logic       soft_reset_req_i,    // Soft reset request pulse
  output logic            cpu_reset_o,         // CPU reset
  output logic            soft_cpu_reset_o,    // CPU soft reset
  output logic            hold_o,              // CPU hold request
  input  wire logic       hlda_i,              // CPU hold acknowledge
  input  wire logic       dma_hold_i,          // DMA hold, synchronous
  output logic            dma_grant_n_o,       // DMA grant, low active
  input  wire logic       vl_req_n_i,          // VL request, low active
  output logic            vl_grant_n_o,        // VL grant, low active
  input  wire logic       refresh_req_i,       // Timer-1 refresh pulse
  output logic            hidden_refresh_o,    // Refresh granted to partner
  input  wire logic       refresh_done_i,      // Refresh finished pulse
  input  wire logic       isa_master_n_i,      // ISA master, low active
  input  wire logic       slow_req_n_i,        // External slow request
  input  wire logic       write_back_request_n_i, // Write-back, low active
  output logic            addr_float_o,        // Float A8:9, A17:23
  output logic            flush_n_o            // Cache flush, low active
);

  typedef enum {CHAA_IDLE, CHAA_CPU_HOLDING, CHAA_DMA, CHAA_VL, CHAA_VL_PREEMPT, CHAA_SETTLE} chaa_own_type;

  chaa_own_type own_r;
  logic [7:0] thr_r, lock_r, mode_r, ctl_r;
  logic       slow_s1_r, slow_s2_r, wb_s1_r, wb_s2_r, wb_prev_r;
  logic       hold_r, reset_pend_r, soft_pend_r, refresh_pend_r, refresh_act_r;
  logic [3:0] wb_cnt_r;
  logic       wb_block_r;
  logic [3:0] settle_r;
  logic [3:0] div_r;
  logic [6:0] thr_cnt_r;
  logic       thr_act_r;
  logic       throttle_on, arb_hold_want, hold_nxt, wb_active, sl_mode;

  assign sl_mode = mode_r[CHAA_SLMODE_BIT];

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      thr_r  <= CHAA_RST_BYTE;
      lock_r <= CHAA_RST_BYTE;
      mode_r <= CHAA_RST_BYTE;
      ctl_r  <= CHAA_RST_BYTE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        CHAA_REG_THROTTLE:  thr_r  <= reg_wdata_i;
        CHAA_REG_LOCK:      lock_r <= reg_wdata_i;
        // (R7) reset mode select
        CHAA_REG_RESETMODE: mode_r <= reg_wdata_i;
        CHAA_REG_CONTROL:   ctl_r  <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        CHAA_REG_THROTTLE:  reg_rdata_o <= thr_r;
        CHAA_REG_LOCK:      reg_rdata_o <= lock_r;
        CHAA_REG_RESETMODE: reg_rdata_o <= mode_r;
        CHAA_REG_CONTROL:   reg_rdata_o <= ctl_r;
        CHAA_REG_STATUS:    reg_rdata_o <= {2'h0, thr_act_r, wb_active, refresh_act_r,
                                            soft_pend_r, reset_pend_r, hold_r};
        default:            reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // (R22) two-flop sync
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      slow_s1_r <= 1'b1;
      slow_s2_r <= 1'b1;
      wb_s1_r   <= 1'b1;
      wb_s2_r   <= 1'b1;
      wb_prev_r <= 1'b1;
    end else begin
      slow_s1_r <= slow_req_n_i;
      slow_s2_r <= slow_s1_r;
      wb_s1_r   <= write_back_request_n_i;
      wb_s2_r   <= wb_s1_r;
      wb_prev_r <= wb_s2_r;
    end
  end

  assign wb_active = ~wb_s2_r;

  // ------------------------------------------------------------
  // Write-back hold removal
  // ------------------------------------------------------------
  // (R13) legacy follows request, other mode fixed window
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wb_cnt_r   <= 4'h0;
      wb_block_r <= 1'b0;
    end else if (wb_active && wb_prev_r) begin
      wb_block_r <= 1'b1;
      wb_cnt_r   <= 4'(CHAA_WB_HOLD_CYC - 1);
    end else if (!ctl_r[CHAA_CTL_WBMODE_BIT]) begin
      wb_block_r <= wb_active;
      wb_cnt_r   <= 4'h0;
    end else if (wb_cnt_r != 4'h0) begin
      wb_cnt_r <= wb_cnt_r - 4'h1;
    end else begin
      wb_block_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // ISA master settling
  // ------------------------------------------------------------
  // (R17) 90 ns guard after master ends
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      settle_r <= 4'h0;
    end else begin
      // Reloaded while the master owns the bus, so the count runs from its release
      if (!isa_master_n_i) begin
        settle_r <= 4'(CHAA_MASTER_SET_CYC);
      end else if (settle_r != 4'h0) begin
        // Long enough for the slow open-collector rise
        settle_r <= settle_r - 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Performance throttle
  // ------------------------------------------------------------
  // (R20) register OR external slow
  assign throttle_on = ctl_r[CHAA_CTL_SLOW_BIT] | ~slow_s2_r;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      div_r     <= 4'h0;
      thr_cnt_r <= 7'h00;
      thr_act_r <= 1'b0;
    end else begin
      div_r <= (div_r == 4'(CHAA_DMACLK_DIV - 1)) ? 4'h0 : div_r + 4'h1;
      // (R18) refresh starts pulse; (R21) 8 MHz ticks
      if (throttle_on && refresh_req_i && thr_r[CHAA_DUR_MSB:0] != 7'h00) begin
        thr_act_r <= 1'b1;
        thr_cnt_r <= thr_r[CHAA_DUR_MSB:0];
      end else if (thr_act_r && div_r == 4'h0) begin
        if (thr_cnt_r <= 7'h01) begin
          thr_act_r <= 1'b0;
          thr_cnt_r <= 7'h00;
        end else begin
          thr_cnt_r <= thr_cnt_r - 7'h01;
        end
      end
    end
  end

  // (R19) separate flush enable
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      flush_n_o <= 1'b1;
    end else begin
      flush_n_o <= ~(thr_act_r & ctl_r[CHAA_CTL_FLUSH_BIT]);
    end
  end

  // ------------------------------------------------------------
  // Hidden refresh vs DMA
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      refresh_pend_r <= 1'b0;
      refresh_act_r  <= 1'b0;
    end else begin
      if (refresh_req_i) begin
        refresh_pend_r <= 1'b1;
      end else if (refresh_pend_r && !refresh_act_r && own_r != CHAA_DMA && !dma_hold_i) begin
        refresh_pend_r <= 1'b0;
      end
      // (R1) never start under DMA; (R2) no hold needed
      if (refresh_act_r && refresh_done_i) begin
        refresh_act_r <= 1'b0;
      end else if (refresh_pend_r && own_r != CHAA_DMA && !dma_hold_i) begin
        refresh_act_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      hidden_refresh_o <= 1'b0;
    end else begin
      // (R3) partner orders refresh against ISA cycles
      hidden_refresh_o <= refresh_act_r;
    end
  end

  // ------------------------------------------------------------
  // Ownership
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      own_r <= CHAA_IDLE;
    end else begin
      case (own_r)
        CHAA_IDLE: begin
          if (dma_hold_i || !vl_req_n_i) begin
            own_r <= CHAA_CPU_HOLDING;
          end
        end
        CHAA_CPU_HOLDING: begin
          if (hold_r && hlda_i && dma_hold_i && !refresh_act_r) begin
            own_r <= CHAA_DMA;
          end else if (hold_r && hlda_i && !vl_req_n_i && settle_r == 4'h0) begin
            own_r <= CHAA_VL;
          end else if (!dma_hold_i && vl_req_n_i) begin
            own_r <= CHAA_IDLE;
          end
        end
        // (R12) owner kept across write-back
        CHAA_DMA: begin
          if (!dma_hold_i && !wb_active) begin
            own_r <= CHAA_SETTLE;
          end
        end
        CHAA_VL: begin
          // (R9) DMA preempts VL master
          if (dma_hold_i && !wb_active) begin
            own_r <= CHAA_VL_PREEMPT;
          end else if (vl_req_n_i && !wb_active) begin
            own_r <= CHAA_IDLE;
          end
        end
        CHAA_VL_PREEMPT: begin
          if (vl_req_n_i) begin
            own_r <= CHAA_CPU_HOLDING;
          end
        end
        CHAA_SETTLE: begin
          if (isa_master_n_i && settle_r == 4'h0) begin
            own_r <= CHAA_IDLE;
          end
        end
        default: own_r <= CHAA_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dma_grant_n_o <= 1'b1;
      vl_grant_n_o  <= 1'b1;
    end else begin
      // (R11) grant stays through write-back
      dma_grant_n_o <= ~(own_r == CHAA_DMA);
      vl_grant_n_o  <= ~(own_r == CHAA_VL);
    end
  end

  // ------------------------------------------------------------
  // CPU hold and reset
  // ------------------------------------------------------------
  // (R6) reset hold joins other requests
  assign arb_hold_want = (own_r != CHAA_IDLE) | (sl_mode & (reset_pend_r | soft_pend_r))
                       | (thr_act_r & thr_r[CHAA_THR_HOLD_BIT]);

  always_comb begin
    hold_nxt = arb_hold_want;
    // (R15) lock stops rising only
    if (lock_r[CHAA_LOCK_BIT] && !hold_r) begin
      hold_nxt = 1'b0;
    end
    // (R11) write-back drops hold
    if (wb_block_r) begin
      hold_nxt = 1'b0;
    end
  end

  // (R10) throttle ORed into hold
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  assign hold_o = hold_r;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reset_pend_r     <= 1'b0;
      soft_pend_r      <= 1'b0;
      cpu_reset_o      <= 1'b0;
      soft_cpu_reset_o <= 1'b0;
    end else begin
      cpu_reset_o      <= 1'b0;
      soft_cpu_reset_o <= 1'b0;
      if (power_good_reset_i) begin
        // (R8) power-good reset unarbitrated
        cpu_reset_o  <= 1'b1;
        reset_pend_r <= 1'b0;
        soft_pend_r  <= 1'b0;
      end else begin
        // (R5) SL mode needs hold and acknowledge; (R16) lock leaves it pending
        if (sl_mode ? (hold_r && hlda_i) : (!hold_r && !hlda_i)) begin
          // (R4) original mode waits out hold
          cpu_reset_o      <= reset_pend_r;
          soft_cpu_reset_o <= soft_pend_r;
          reset_pend_r     <= cpu_reset_req_i;
          soft_pend_r      <= soft_reset_req_i;
        end else begin
          reset_pend_r <= reset_pend_r | cpu_reset_req_i;
          soft_pend_r  <= soft_pend_r | soft_reset_req_i;
        end
      end
    end
  end

  // (R14) float address for DMA write-back
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      addr_float_o <= 1'b0;
    end else begin
      addr_float_o <= (own_r == CHAA_DMA) & wb_active;
    end
  end

endmodule

// ---- tb/chaa_arbiter_assertions.sv ----
`timescale 1ns/100ps
module chaa_arbiter_assertions
  import chaa_pkg::*;
(
  input wire logic       sys_clk_i,              // Clock
  input wire logic       srst_i,                 // Reset
  input wire logic [7:0] reg_addr_i,             // Index
  input wire logic [7:0] reg_wdata_i,            // Write data
  input wire logic       reg_wr_i,               // Write strobe
  input wire logic       power_good_reset_i,     // Power-good reset
  input wire logic       cpu_reset_o,            // CPU reset
  input wire logic       hold_o,                 // Hold
  input wire logic       hlda_i,                 // Hold ack
  input wire logic       dma_hold_i,             // DMA hold
  input wire logic       dma_grant_n_o,          // DMA grant
  input wire logic       vl_grant_n_o,           // VL grant
  input wire logic       hidden_refresh_o,       // Refresh
  input wire logic       isa_master_n_i,         // ISA master
  input wire logic       write_back_request_n_i, // Write-back
  input wire logic       addr_float_o            // Float
);
  logic sl_r;
  logic lock_r;
  // Shadow of mode and lock bits, same write timing as the block
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sl_r   <= 1'b0;
      lock_r <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == CHAA_REG_RESETMODE) sl_r <= reg_wdata_i[CHAA_SLMODE_BIT];
      if (reg_addr_i == CHAA_REG_LOCK) lock_r <= reg_wdata_i[CHAA_LOCK_BIT];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  refresh_dma_excl_a: assert property (!(hidden_refresh_o && !dma_grant_n_o))
    else $error("refresh and dma grant together");
  orig_reset_a: assert property (cpu_reset_o && !$past(power_good_reset_i) && !$past(sl_r)
    |-> $past(!hold_o && !hlda_i)) else $error("reset while in hold");
  sl_reset_a: assert property (cpu_reset_o && !$past(power_good_reset_i) && $past(sl_r)
    |-> $past(hold_o && hlda_i)) else $error("reset outside hold");
  pg_reset_a: assert property (power_good_reset_i |=> cpu_reset_o)
    else $error("power-good reset not passed");
  vl_preempt_a: assert property (dma_hold_i && !vl_grant_n_o && write_back_request_n_i
    |-> ##[1:3] vl_grant_n_o) else $error("vl grant not withdrawn");
  wb_hold_drop_a: assert property ($fell(write_back_request_n_i) && hold_o
    |-> ##[1:6] !hold_o) else $error("hold kept at write back");
  wb_grant_keep_a: assert property (!dma_grant_n_o && !write_back_request_n_i
    |=> !dma_grant_n_o) else $error("grant lost during write back");
  dma_float_a: assert property (addr_float_o |-> !dma_grant_n_o)
    else $error("float without dma owner");
  lock_hold_a: assert property ($rose(hold_o) |-> !$past(lock_r))
    else $error("hold rose while locked");
  isa_settle_a: assert property ($rose(isa_master_n_i) |-> vl_grant_n_o [*8])
    else $error("vl grant too soon after isa master");
  cover property (sl_r && cpu_reset_o);
  cover property (addr_float_o);
  cover property (dma_hold_i && !vl_grant_n_o);
endmodule
bind chaa_arbiter chaa_arbiter_assertions u_chaa_arbiter_assertions (.sys_clk_i(sys_clk_i),
  .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .power_good_reset_i(power_good_reset_i), .cpu_reset_o(cpu_reset_o), .hold_o(hold_o), .hlda_i(hlda_i),
  .dma_hold_i(dma_hold_i), .dma_grant_n_o(dma_grant_n_o), .vl_grant_n_o(vl_grant_n_o),
  .hidden_refresh_o(hidden_refresh_o), .isa_master_n_i(isa_master_n_i),
  .write_back_request_n_i(write_back_request_n_i), .addr_float_o(addr_float_o));

// ---- tb/chaa_cpu_model.sv ----
`timescale 1ns/100ps
module chaa_cpu_model (
  input  wire logic sys_clk_i,    // Clock
  input  wire logic srst_i,       // Reset
  input  wire logic hold_i,       // Hold request
  input  wire logic slow_i,       // Slow acknowledge
  input  wire logic vl_want_i,    // VL master wants bus
  input  wire logic vl_grant_n_i, // VL grant
  output logic      hlda_o,       // Hold acknowledge
  output logic      vl_req_n_o    // VL request
);
  logic [2:0] dly_r;
  logic       own_r;
  // CPU acknowledges hold after a short or long delay
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !hold_i) begin
      dly_r  <= 3'h0;
      hlda_o <= 1'b0;
    end else begin
      if (dly_r != 3'h7) dly_r <= dly_r + 3'h1;
      hlda_o <= dly_r >= (slow_i ? 3'h5 : 3'h1);
    end
  end
  // master gives up bus once grant is withdrawn
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      vl_req_n_o <= 1'b1;
      own_r      <= 1'b0;
    end else if (own_r && vl_grant_n_i) begin
      vl_req_n_o <= 1'b1;
      own_r      <= 1'b0;
    end else begin
      vl_req_n_o <= !vl_want_i;
      own_r      <= own_r | !vl_grant_n_i;
    end
  end
endmodule

// ---- tb/cpu_hold_auxiliary_arbitration_test.sv ----
`timescale 1ns/100ps
module cpu_hold_auxiliary_arbitration_test;
  import chaa_pkg::*;
  logic clk, rst, wr, rd, pg, crq, srq, dmah, isam_n, slow_n, wb_n, refq, refd, cslow, vwant;
  logic [7:0] addr, wdat, rdat;
  logic hold, hlda, dma_grant_n_n, vreq_n, vgnt_n, href, crst, sft, flt, flush_n;
  logic [2:0] rcnt;
  int failures, checked, n;
  chaa_arbiter u_chaa_arbiter (.sys_clk_i(clk), .srst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdat),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .power_good_reset_i(pg), .cpu_reset_req_i(crq),
    .soft_reset_req_i(srq), .cpu_reset_o(crst), .soft_cpu_reset_o(sft), .hold_o(hold), .hlda_i(hlda),
    .dma_hold_i(dmah), .dma_grant_n_o(dma_grant_n_n), .vl_req_n_i(vreq_n), .vl_grant_n_o(vgnt_n),
    .refresh_req_i(refq), .hidden_refresh_o(href), .refresh_done_i(refd), .isa_master_n_i(isam_n),
    .slow_req_n_i(slow_n), .write_back_request_n_i(wb_n), .addr_float_o(flt), .flush_n_o(flush_n));
  chaa_cpu_model u_chaa_cpu_model (.sys_clk_i(clk), .srst_i(rst), .hold_i(hold), .slow_i(cslow),
    .vl_want_i(vwant), .vl_grant_n_i(vgnt_n), .hlda_o(hlda), .vl_req_n_o(vreq_n));
  // partner chip finishes the hidden refresh after a gap
  always @(posedge clk) begin
    rcnt <= (href && !refd) ? rcnt + 3'h1 : 3'h0;
    refd <= (rcnt == 3'h6);
  end
  task automatic stop_test;
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp1(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: read %h", $time, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 cmp8(rdat, e);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return hold;
      1: return vgnt_n;
      2: return dma_grant_n_n;
      3: return crst;
      4: return href;
      default: return sft;
    endcase
  endfunction
  // Bounded wait on one design output
  task automatic wait_sig(input int s, input logic v);
    n = 0;
    while (sig(s) !== v) begin
      @(posedge clk);
      #1 n++;
      if (n > 300) begin
        failures++;
        $display("unexpected at %0t: wait %0d timed out", $time, s);
        stop_test();
      end
    end
  endtask
  task automatic pulse(input int s);
    @(posedge clk);
    crq  <= (s == 0);
    srq  <= (s == 1);
    refq <= (s == 2);
    @(posedge clk) {crq, srq, refq} <= 3'h0;
  endtask
  task automatic t_regs;
    wr_reg(CHAA_REG_THROTTLE, 8'h85);
    rd_reg(CHAA_REG_THROTTLE, 8'h85);
    rd_reg(CHAA_REG_LOCK, CHAA_RST_BYTE);
    rd_reg(CHAA_REG_RESETMODE, CHAA_RST_BYTE);
    rd_reg(8'h5A, 8'h00);
  endtask
  task automatic t_refresh;
    pulse(2);
    wait_sig(4, 1'b1);
    cmp1(hold, 1'b0, "hold raised for hidden refresh");
    @(posedge clk) dmah <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp1(dma_grant_n_n, 1'b1, "dma granted during refresh");
    wait_sig(2, 1'b0);
    cmp1(href, 1'b0, "refresh still active");
  endtask
  task automatic t_reset_orig;
    pulse(0);
    repeat (20) @(posedge clk);
    @(posedge clk) dmah <= 1'b0;
    wait_sig(3, 1'b1);
    cmp1(hlda, 1'b0, "reset while in hold");
  endtask
  task automatic t_reset_sl;
    wr_reg(CHAA_REG_RESETMODE, 8'h08);
    @(posedge clk) pg <= 1'b1;
    @(posedge clk) pg <= 1'b0;
    #1 cmp1(crst, 1'b1, "power-good reset held back");
    for (int k = 0; k < 2; k++) begin
      pulse(k);
      wait_sig(k ? 5 : 3, 1'b1);
      cmp1(hlda, 1'b1, "reset outside hold");
    end
    @(posedge clk) dmah <= 1'b1;
    wait_sig(2, 1'b0);
    pulse(0);
    wait_sig(3, 1'b1);
    cmp1(dma_grant_n_n, 1'b0, "dma lost bus at reset");
    @(posedge clk) dmah <= 1'b0;
    wait_sig(0, 1'b0);
    wr_reg(CHAA_REG_LOCK, 8'h01);
    pulse(0);
    repeat (40) @(posedge clk);
    #1 cmp1(hold, 1'b0, "hold rose while locked");
    wr_reg(CHAA_REG_LOCK, 8'h00);
    wait_sig(3, 1'b1);
    wr_reg(CHAA_REG_RESETMODE, 8'h00);
  endtask
  task automatic t_preempt;
    @(posedge clk) vwant <= 1'b1;
    wait_sig(1, 1'b0);
    @(posedge clk) dmah <= 1'b1;
    wait_sig(1, 1'b1);
    @(posedge clk) vwant <= 1'b0;
    wait_sig(2, 1'b0);
    cmp1(vreq_n, 1'b1, "vl request not released");
    @(posedge clk) isam_n <= 1'b0;
    @(posedge clk) wb_n <= 1'b0;
    wait_sig(0, 1'b0);
    cmp1(dma_grant_n_n, 1'b0, "grant lost at write back");
    @(posedge clk) dmah <= 1'b0;
    repeat (6) @(posedge clk);
    #1 cmp1(dma_grant_n_n, 1'b0, "grant lost before write back end");
    cmp1(flt, 1'b1, "address lines driven");
    cmp1(hold, 1'b0, "hold back during legacy write back");
    @(posedge clk) wb_n <= 1'b1;
    @(posedge clk) vwant <= 1'b1;
    @(posedge clk) isam_n <= 1'b1;
    repeat (CHAA_MASTER_SET_CYC) @(posedge clk);
    #1 cmp1(vgnt_n, 1'b1, "vl granted inside isa settle");
    wait_sig(1, 1'b0);
    @(posedge clk) vwant <= 1'b0;
    wait_sig(1, 1'b1);
  endtask
  task automatic t_wb4;
    wr_reg(CHAA_REG_CONTROL, 8'h04);
    @(posedge clk) dmah <= 1'b1;
    wait_sig(2, 1'b0);
    @(posedge clk) wb_n <= 1'b0;
    wait_sig(0, 1'b0);
    repeat (3) @(posedge clk);
    #1 cmp1(hold, 1'b0, "hold back inside window");
    repeat (3) @(posedge clk);
    #1 cmp1(hold, 1'b1, "hold not back after window");
    @(posedge clk) wb_n <= 1'b1;
    @(posedge clk) dmah <= 1'b0;
    wait_sig(2, 1'b1);
  endtask
  task automatic t_throttle;
    wr_reg(CHAA_REG_THROTTLE, 8'h82);
    for (int k = 0; k < 3; k++) begin
      wr_reg(CHAA_REG_CONTROL, (k == 0) ? 8'h03 : 8'h00);
      @(posedge clk);
      slow_n <= (k != 1);
      cslow  <= (k == 1);
      repeat (2) @(posedge clk);
      wait_sig(4, 1'b0);
      pulse(2);
      repeat (3) @(posedge clk);
      #1 cmp1(hold, (k != 2), "throttle hold state");
      cmp1(flush_n, (k != 0), "flush state");
      n = 0;
      while (hold === 1'b1 && n < 100) begin
        @(posedge clk);
        #1 n++;
      end
      cmp1(k == 2 || (n >= CHAA_DMACLK_DIV - 1 && n <= 2 * CHAA_DMACLK_DIV - 2), 1'b1, "hold length");
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, wr, rd, pg, crq, srq, dmah, refq, refd, cslow, vwant} = 11'h400;
    {isam_n, slow_n, wb_n} = 3'h7;
    addr = 8'h00;
    wdat = 8'h00;
    rcnt = 3'h0;
    failures = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_refresh();
    t_reset_orig();
    t_reset_sl();
    t_preempt();
    t_wb4();
    t_throttle();
    stop_test();
  end
endmodule
